// >>> design/dct_top.sv
// DRAM pin connectivity test: entry sequencing, minterm outputs, output enables
`timescale 1ns/1ps
module dct_top (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_test_enable_pin,
	input  wire logic                      i_cs_n,
	input  wire logic                      i_has_a17,
	input  wire dct_pkg::dct_tin_s         i_tin,
	input  wire logic                      i_mem_dq_oe,
	input  wire logic [dct_pkg::DQ_W-1:0]  i_mem_dq,
	input  wire logic                      i_mem_refresh_req,
	output dct_pkg::dct_tout_s             o_tout,
	output logic      [dct_pkg::DQ_W-1:0]  o_dq_oe,
	output logic                           o_strb_oe,
	output logic                           o_continuity_check_mode,
	output logic                           o_clk_inputs_live,
	output logic                           o_inputs_live,
	output logic                           o_vref_half_sel,
	output logic                           o_refresh_allow,
	output logic                           o_reinit_required
);
	localparam int unsigned TIN_W = $bits(dct_pkg::dct_tin_s);

	logic rst_meta_q;
	logic rst_sync_q;

	// Reset release through two flops
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_q <= 1'h0;
			rst_sync_q <= 1'h0;
		end else begin
			rst_meta_q <= 1'h1;
			rst_sync_q <= rst_meta_q;
		end
	end

	logic              ten_s;
	logic              cs_n_s;
	logic              has_a17_s;
	logic [TIN_W-1:0]  tin_raw;
	dct_pkg::dct_tin_s tin_s;

	dct_sync #(.W(1)) u_sync_ten (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_sync_q),
		.i_d     (i_test_enable_pin),
		.o_q     (ten_s)
	);

	dct_sync #(.W(1)) u_sync_cs (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_sync_q),
		.i_d     (i_cs_n),
		.o_q     (cs_n_s)
	);

	// Strap is a pin too; same two-flop delay keeps it aligned with the pattern
	dct_sync #(.W(1)) u_sync_a17 (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_sync_q),
		.i_d     (i_has_a17),
		.o_q     (has_a17_s)
	);

	dct_sync #(.W(TIN_W)) u_sync_tin (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_sync_q),
		.i_d     (i_tin),
		.o_q     (tin_raw)
	);

	assign tin_s = dct_pkg::dct_tin_s'(tin_raw);

	dct_pkg::dct_tout_s mt_out;

	// Parallel combinational test function from sampled pins
	dct_minterm u_minterm (
		.i_ten     (ten_s),
		.i_has_a17 (has_a17_s),
		.i_tin     (tin_s),
		.o_tout    (mt_out)
	);

	dct_pkg::dct_state_e            st_q;
	dct_pkg::dct_state_e            st_d;
	logic [dct_pkg::CNT_W-1:0]      cnt_q;
	logic [dct_pkg::CNT_W-1:0]      cnt_d;
	logic [dct_pkg::CNT_W-1:0]      vld_q;
	logic [dct_pkg::CNT_W-1:0]      vld_d;
	logic                           clk_live_q;
	logic                           clk_live_d;
	logic                           reinit_q;
	logic                           reinit_d;
	logic [TIN_W-1:0]               tin_prev_q;
	logic                           in_mode;
	logic                           inputs_stable;

	assign in_mode = (st_q != dct_pkg::ST_IDLE);
	assign inputs_stable = (vld_q >= dct_pkg::CNT_W'(dct_pkg::INPUT_VALID_CYC));

	// Entry sequencer and input stability counter
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		clk_live_d = clk_live_q;
		reinit_d   = reinit_q;
		vld_d      = (tin_raw != tin_prev_q) ? '0 :
			(inputs_stable ? vld_q : vld_q + dct_pkg::CNT_W'(1));
		if (!ten_s) begin
			if (in_mode) begin
				reinit_d = 1'h1;
			end
			st_d       = dct_pkg::ST_IDLE;
			cnt_d      = '0;
			clk_live_d = 1'h0;
		end else begin
			case (st_q)
				dct_pkg::ST_IDLE: begin
					st_d  = dct_pkg::ST_CLKIN;
					cnt_d = '0;
				end
				dct_pkg::ST_CLKIN: begin
					cnt_d = cnt_q + dct_pkg::CNT_W'(1);
					if (cnt_q + dct_pkg::CNT_W'(1) >=
						dct_pkg::CNT_W'(dct_pkg::CLKIN_VALID_CYC)) begin
						clk_live_d = 1'h1;
						st_d       = dct_pkg::ST_ENABLE;
						cnt_d      = '0;
					end
				end
				dct_pkg::ST_ENABLE: begin
					if (!cs_n_s) begin
						cnt_d = cnt_q + dct_pkg::CNT_W'(1);
					end
					if (!cs_n_s && inputs_stable && cnt_q + dct_pkg::CNT_W'(1) >=
						dct_pkg::CNT_W'(dct_pkg::ENABLE_DELAY_CYC)) begin
						st_d = dct_pkg::ST_ACTIVE;
					end
				end
				dct_pkg::ST_ACTIVE: begin
					st_d = dct_pkg::ST_ACTIVE;
				end
				default: begin
					st_d = dct_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			st_q       <= dct_pkg::ST_IDLE;
			cnt_q      <= '0;
			vld_q      <= '0;
			clk_live_q <= 1'h0;
			reinit_q   <= 1'h0;
			tin_prev_q <= '0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			vld_q      <= vld_d;
			clk_live_q <= clk_live_d;
			reinit_q   <= reinit_d;
			tin_prev_q <= tin_raw;
		end
	end

	dct_pkg::dct_tout_s               tout_d;
	logic [dct_pkg::DQ_W-1:0]         dq_oe_d;
	logic                             strb_oe_d;
	logic                             live_d;
	logic                             refresh_d;
	logic                             vref_d;

	// Output mux: test results once active, zeros earlier in test mode, memory path otherwise
	always_comb begin
		live_d    = (st_q == dct_pkg::ST_ACTIVE);
		vref_d    = in_mode ? dct_pkg::VREF_HALF : 1'h0;
		refresh_d = ~in_mode & i_mem_refresh_req;
		if (in_mode) begin
			tout_d    = live_d ? mt_out : '0;
			dq_oe_d   = {dct_pkg::DQ_W{live_d & ~cs_n_s}};
			strb_oe_d = live_d & ~cs_n_s;
		end else begin
			tout_d    = '0;
			tout_d.dq = i_mem_dq;
			dq_oe_d   = {dct_pkg::DQ_W{i_mem_dq_oe}};
			strb_oe_d = i_mem_dq_oe;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_tout                  <= '0;
			o_dq_oe                 <= '0;
			o_strb_oe               <= 1'h0;
			o_continuity_check_mode <= 1'h0;
			o_clk_inputs_live       <= 1'h0;
			o_inputs_live           <= 1'h0;
			o_vref_half_sel         <= 1'h0;
			o_refresh_allow         <= 1'h0;
			o_reinit_required       <= 1'h0;
		end else begin
			o_tout                  <= tout_d;
			o_dq_oe                 <= dq_oe_d;
			o_strb_oe               <= strb_oe_d;
			o_continuity_check_mode <= in_mode;
			o_clk_inputs_live       <= clk_live_q;
			o_inputs_live           <= live_d;
			o_vref_half_sel         <= vref_d;
			o_refresh_allow         <= refresh_d;
			o_reinit_required       <= reinit_q;
		end
	end
endmodule

// >>> design/dct_pkg.sv
// Package for the DRAM pin connectivity test block: pin groups, timings, states
package dct_pkg;

	localparam int unsigned CLK_PERIOD_PS = 4000;

	// Input validity, enable delay and clock-input validity times in ns (plain defaults)
	localparam int unsigned INPUT_VALID_NS  = 200;
	localparam int unsigned ENABLE_DELAY_NS = 10;
	localparam int unsigned CLKIN_VALID_NS  = 200;

	// Least times round up to whole cycles
	localparam int unsigned INPUT_VALID_CYC  = (INPUT_VALID_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned ENABLE_DELAY_CYC = (ENABLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned CLKIN_VALID_CYC  = (CLKIN_VALID_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

	localparam int unsigned CNT_W = 8;
	localparam int unsigned DQ_W  = 16;
	localparam int unsigned MT_N  = 10;
	localparam int unsigned HALF  = 8;

	// Vref select code: 1 forces half of output supply
	localparam logic VREF_HALF = 1'h1;

	typedef struct packed {
		logic [17:0] addr;
		logic [1:0]  bank;
		logic        bank_grp0;
		logic        act_n;
		logic        cke;
		logic        odt;
		logic        ck_t;
		logic        ck_c;
		logic        par;
		logic        dm_upper_n;
		logic        dm_lower_n;
		logic        alert_n;
		logic        reset_n;
	} dct_tin_s;

	typedef struct packed {
		logic [DQ_W-1:0] dq;
		logic            strb_lo_t;
		logic            strb_lo_c;
		logic            strb_up_t;
		logic            strb_up_c;
	} dct_tout_s;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_CLKIN  = 4'h2,
		ST_ENABLE = 4'h4,
		ST_ACTIVE = 4'h8
	} dct_state_e;

endpackage

// >>> design/dct_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
module dct_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb begin
		meta_d = i_d;
		q_d    = meta_q;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= meta_d;
			o_q    <= q_d;
		end
	end
endmodule

// >>> design/dct_minterm.sv
// Minterm logic: XOR terms of test inputs mapped onto DQ and strobes
`timescale 1ns/1ps
module dct_minterm (
	input  wire logic                 i_ten,
	input  wire logic                 i_has_a17,
	input  wire dct_pkg::dct_tin_s    i_tin,
	output dct_pkg::dct_tout_s        o_tout
);
	logic [dct_pkg::MT_N-1:0] mt;
	logic [17:0]              a;

	always_comb begin
		a     = i_tin.addr;
		mt[0] = a[1] ^ a[6] ^ i_tin.par;
		mt[1] = a[8] ^ i_tin.alert_n ^ a[9];
		mt[2] = a[2] ^ a[5] ^ a[13] ^ (i_has_a17 & a[17]);
		mt[3] = a[0] ^ a[7] ^ a[11];
		mt[4] = i_tin.ck_c ^ i_tin.odt ^ a[15];
		mt[5] = i_tin.cke ^ a[16] ^ a[10];
		mt[6] = i_tin.act_n ^ a[4] ^ i_tin.bank[1];
		mt[7] = i_tin.dm_upper_n ^ i_tin.dm_lower_n ^ i_tin.ck_t;
		mt[8] = a[14] ^ a[12] ^ i_tin.bank[0];
		mt[9] = i_tin.bank_grp0 ^ a[3] ^ (i_tin.reset_n & i_ten);
	end

	genvar g;
	generate
		for (g = 0; g < dct_pkg::HALF; g++) begin : g_dq
			assign o_tout.dq[g]                 = mt[g];
			assign o_tout.dq[g + dct_pkg::HALF] = ~mt[g];
		end
	endgenerate

	assign o_tout.strb_lo_t = mt[8];
	assign o_tout.strb_lo_c = mt[9];
	assign o_tout.strb_up_t = ~mt[8];
	assign o_tout.strb_up_c = ~mt[9];
endmodule

// >>> testbench/dct_checker.sv
// Port-level assertions for the connectivity test block
`timescale 1ns/1ps
module dct_checker (
	input wire logic                     i_ref_clk,
	input wire logic                     i_rst_n,
	input wire logic                     i_test_enable_pin,
	input wire logic                     i_cs_n,
	input wire dct_pkg::dct_tin_s        i_tin,
	input wire dct_pkg::dct_tout_s       o_tout,
	input wire logic [dct_pkg::DQ_W-1:0] o_dq_oe,
	input wire logic                     o_strb_oe,
	input wire logic                     o_continuity_check_mode,
	input wire logic                     o_clk_inputs_live,
	input wire logic                     o_inputs_live,
	input wire logic                     o_vref_half_sel,
	input wire logic                     o_refresh_allow,
	input wire logic                     o_reinit_required
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_mode_entry: assert property ($rose(i_test_enable_pin) |->
		##[3:6] o_continuity_check_mode)
		else $error("mode not entered after enable rose");
	a_mode_exit: assert property ($fell(i_test_enable_pin) |->
		##[2:5] !o_continuity_check_mode)
		else $error("mode not left after enable fell");
	a_vref_half: assert property (o_continuity_check_mode |->
		o_vref_half_sel)
		else $error("reference not forced to half in test mode");
	a_refresh_block: assert property (o_continuity_check_mode |->
		!o_refresh_allow)
		else $error("refresh allowed in test mode");
	a_oe_deselect: assert property (i_cs_n [*4] |->
		(o_dq_oe == '0) && !o_strb_oe)
		else $error("outputs enabled while deselected");
	a_oe_select: assert property ((o_inputs_live && !i_cs_n) [*4] |->
		(o_dq_oe == '1) && o_strb_oe)
		else $error("outputs not enabled while selected in test mode");
	a_dq_pairs: assert property (o_inputs_live |->
		o_tout.dq[15:8] == ~o_tout.dq[7:0])
		else $error("upper data not inverse of lower");
	a_strobe_pairs: assert property (o_inputs_live |->
		{o_tout.strb_up_t, o_tout.strb_up_c} == ~{o_tout.strb_lo_t, o_tout.strb_lo_c})
		else $error("upper strobes not inverse of lower");
	a_live_order: assert property (o_inputs_live |->
		o_continuity_check_mode && o_clk_inputs_live)
		else $error("inputs live outside test mode");
	a_term_zero: assert property (o_inputs_live |-> o_tout.dq[0] ==
		($past(i_tin.addr[1], 3) ^ $past(i_tin.addr[6], 3) ^ $past(i_tin.par, 3)))
		else $error("first data bit wrong for applied pattern");
	a_reinit_sticky: assert property (o_reinit_required |=>
		o_reinit_required)
		else $error("reinit flag cleared without reset");
endmodule

bind dct_top dct_checker u_dct_checker (.i_ref_clk, .i_rst_n, .i_test_enable_pin, .i_cs_n,
	.i_tin, .o_tout, .o_dq_oe, .o_strb_oe, .o_continuity_check_mode, .o_clk_inputs_live,
	.o_inputs_live, .o_vref_half_sel, .o_refresh_allow, .o_reinit_required);

// >>> testbench/dct_agent.sv
// Board test agent model: drives enable, select and test patterns
`timescale 1ns/1ps
module dct_agent (
	input  wire logic               i_por_done,
	input  wire logic               i_enter,
	input  wire logic               i_sel,
	input  wire dct_pkg::dct_tin_s  i_pat,
	output logic                    o_ten,
	output logic                    o_cs_n,
	output dct_pkg::dct_tin_s       o_tin
);
	always_comb begin
		o_ten = i_enter & i_por_done;
		o_cs_n = ~i_sel;
		o_tin = i_pat;
		o_tin.reset_n = 1'h1;
	end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the connectivity test block
`timescale 1ns/1ps
module tb_top;
	logic               clk = 1'h0;
	logic               rst_n = 1'h0;
	logic               por_done = 1'h0;
	logic               enter = 1'h0;
	logic               sel = 1'h1;
	logic               has_a17 = 1'h1;
	logic               mem_oe = 1'h0;
	logic [15:0]        mem_dq = 16'hA5C3;
	logic               ref_req = 1'h0;
	dct_pkg::dct_tin_s  pat = '0;
	dct_pkg::dct_tin_s  tin;
	dct_pkg::dct_tout_s tout;
	logic [15:0]        dq_oe;
	logic               test_enable_pin, cs_n, strb_oe, mode, clk_live, live, vref, ref_ok, reinit;
	int                 failures = 0;
	int                 checked = 0;

	always #2 clk = ~clk;

	dct_agent u_dct_agent (.i_por_done(por_done), .i_enter(enter), .i_sel(sel), .i_pat(pat),
		.o_ten(test_enable_pin), .o_cs_n(cs_n), .o_tin(tin));
	dct_top u_dct_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_test_enable_pin(test_enable_pin),
		.i_cs_n(cs_n), .i_has_a17(has_a17), .i_tin(tin), .i_mem_dq_oe(mem_oe),
		.i_mem_dq(mem_dq), .i_mem_refresh_req(ref_req), .o_tout(tout), .o_dq_oe(dq_oe),
		.o_strb_oe(strb_oe), .o_continuity_check_mode(mode), .o_clk_inputs_live(clk_live),
		.o_inputs_live(live), .o_vref_half_sel(vref), .o_refresh_allow(ref_ok),
		.o_reinit_required(reinit));

	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: vector got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = mode;
			1: pick = live;
			default: pick = ref_ok;
		endcase
	endfunction

	task automatic wait_for(input int w, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(w) !== v) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				failures++;
				$display("mismatch at %0t: wait ran out", $time);
				give_verdict();
			end
		end
	endtask

	function automatic dct_pkg::dct_tout_s expect_out(input dct_pkg::dct_tin_s t, input logic a);
		logic [9:0] m;
		m[0] = t.addr[1] ^ t.addr[6] ^ t.par;
		m[1] = t.addr[8] ^ t.alert_n ^ t.addr[9];
		m[2] = t.addr[2] ^ t.addr[5] ^ t.addr[13] ^ (a & t.addr[17]);
		m[3] = t.addr[0] ^ t.addr[7] ^ t.addr[11];
		m[4] = t.ck_c ^ t.odt ^ t.addr[15];
		m[5] = t.cke ^ t.addr[16] ^ t.addr[10];
		m[6] = t.act_n ^ t.addr[4] ^ t.bank[1];
		m[7] = t.dm_upper_n ^ t.dm_lower_n ^ t.ck_t;
		m[8] = t.addr[14] ^ t.addr[12] ^ t.bank[0];
		m[9] = t.bank_grp0 ^ t.addr[3] ^ t.reset_n;
		return {~m[7:0], m[7:0], m[8], m[9], ~m[8], ~m[9]};
	endfunction

	task automatic t_normal();
		@(negedge clk);
		ref_req = 1'h1;
		mem_oe = 1'h1;
		wait_for(2, 1'h1, 10);
		chk_bit(mode, 1'h0);
		chk_bit(ref_ok, 1'h1);
		chk_vec(tout, {mem_dq, 4'h0});
		chk_vec({4'h0, dq_oe}, 20'h0FFFF);
		chk_bit(vref, 1'h0);
	endtask

	task automatic t_enter();
		@(negedge clk);
		por_done = 1'h1;
		enter = 1'h1;
		wait_for(0, 1'h1, 10);
		chk_bit(vref, 1'h1);
		chk_bit(ref_ok, 1'h0);
		wait_for(1, 1'h1, 400);
		chk_bit(clk_live, 1'h1);
		repeat (2) @(negedge clk);
		chk_vec({4'h0, dq_oe}, 20'h0FFFF);
		chk_bit(strb_oe, 1'h1);
		chk_vec(tout, expect_out(tin, has_a17));
	endtask

	task automatic t_patterns();
		for (int a = 0; a < 2; a++) begin
			for (int i = 0; i < 31; i++) begin
				@(negedge clk);
				has_a17 = a[0];
				pat = dct_pkg::dct_tin_s'(31'h1 << i);
				repeat (6) @(negedge clk);
				wait_for(1, 1'h1, 400);
				repeat (4) @(negedge clk);
				chk_vec(tout, expect_out(tin, has_a17));
			end
		end
	endtask

	task automatic t_cs();
		@(negedge clk);
		sel = 1'h0;
		repeat (6) @(negedge clk);
		chk_vec({4'h0, dq_oe}, 20'h00000);
		chk_bit(strb_oe, 1'h0);
		sel = 1'h1;
		repeat (6) @(negedge clk);
		wait_for(1, 1'h1, 400);
		repeat (2) @(negedge clk);
		chk_vec({4'h0, dq_oe}, 20'h0FFFF);
	endtask

	task automatic t_exit();
		@(negedge clk);
		enter = 1'h0;
		wait_for(0, 1'h0, 10);
		repeat (2) @(negedge clk);
		chk_bit(reinit, 1'h1);
		chk_bit(live, 1'h0);
		chk_bit(vref, 1'h0);
		chk_vec(tout, {mem_dq, 4'h0});
		wait_for(2, 1'h1, 10);
		rst_n = 1'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) @(negedge clk);
		chk_bit(reinit, 1'h0);
		chk_bit(mode, 1'h0);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) @(negedge clk);
		t_normal();
		t_enter();
		t_patterns();
		t_cs();
		t_exit();
		give_verdict();
	end
endmodule
